// >>> verilog/osdm_access_ctrl.sv
// OSD glyph and screen memory access logic behind an AXI4-Lite register slave
// Overview of operation
// [R1] Mode 0101xxxx copies glyph into shadow RAM
// [R2] Glyph high address picks character 0-255
// [R3] Glyph low address picks shadow byte 0-63
// [R4] Data-out read returns selected shadow byte
// [R5] Store keeps glyph memory busy 12ms
// [R6] Host disables overlay around glyph reads
// [R7] Overlay bit shows image; screen access unaffected
// [R8] Host read-modify-writes black level bit 4
// [R9] Mode bit 2 clears screen, 20us
// [R10] Host waits for clear before mode write
// [R11] Clear bit self-clears when clear ends
// [R12] Mode bit 6 selects byte-wide writes
// [R13] High address bit 1 picks code/attribute
// [R14] Position is high bit 0 plus low
// [R15] Data-in write stores byte at position
// [R16] Word mode copies mode attribute bits
// [R17] Mode bits 5:3 hold attribute flags
// [R18] Mode bit 0 enables auto-increment
// [R19] Auto-increment advances position after write
// [R20] FFH write ends auto-increment, not stored
// [R21] Status bit 5 high while glyph busy
// [R22] Pixel pairs: 00 black, 10 white
// [R23] Mode writes ignored while clear runs
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module osdm_access_ctrl #(
   parameter int STORE_CYC = osdm_pkg::STORE_CYCLES,
   parameter logic [3:0] FACTORY_PRESET = 4'h0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic overlayVisible,
   output logic blackLevelAuto
);
   import osdm_pkg::*;

   localparam int CLR_W = $clog2(CLEAR_CYCLES + 1);
   localparam int ST_W = $clog2(STORE_CYC + 1);

   // Bus capture
   logic awHave, wHave;
   logic [7:0] wAddr;
   logic [7:0] wByte;
   logic wLane;
   logic wrFire;
   logic wrMapped;
   // Registers
   logic [7:0] videoModeCtrl0;
   logic [7:0] overlayBlackLevel;
   logic [7:0] glyphAddrHigh;
   logic [5:0] glyphAddrLow;
   logic [6:0] screenMemMode;
   logic [1:0] screenAddrHigh;
   logic [7:0] screenAddrLow;
   // Memories
   logic [7:0] glyphNvm [GLYPH_COUNT*GLYPH_BYTES];
   logic [7:0] shadowRam [GLYPH_BYTES];
   logic [7:0] screenCode [SCREEN_POSITIONS];
   logic [2:0] screenAttr [SCREEN_POSITIONS];
   logic [SCREEN_POSITIONS-1:0] screenValid;
   // Sequencers
   osdm_glyph_state_t glyphState;
   logic [5:0] glyphIdx;
   logic [ST_W-1:0] storeCnt;
   logic [CLR_W-1:0] clearCnt;
   logic glyphBusy, clearing;
   logic [8:0] position;
   logic [13:0] nvmBase;
   logic wrGlyphIn, wrGlyphCmd, wrScreenIn, wrMode, storeData;
   logic [7:0] next_rdata;
   logic next_rerr;

   assign wrFire = awHave && wHave && !s_axi_bvalid;
   assign glyphBusy = (glyphState != GS_IDLE);
   assign clearing = screenMemMode[BIT_MODE_CLEAR];
   assign position = {screenAddrHigh[BIT_POS_MSB], screenAddrLow}; // [R14]
   assign nvmBase = {glyphAddrHigh, 6'h00}; // [R2]
   assign wrMapped = (wAddr <= OFF_STATUS) && (wAddr[1:0] == 2'b00) && (wAddr != OFF_GLYPH_DATA_OUT)
      && (wAddr != OFF_SCREEN_DATA_OUT) && (wAddr != OFF_STATUS);
   assign wrGlyphIn = wrFire && wLane && (wAddr == OFF_GLYPH_DATA_IN) && !glyphBusy;
   assign wrGlyphCmd = wrFire && wLane && (wAddr == OFF_GLYPH_MEM_MODE) && !glyphBusy;
   assign wrScreenIn = wrFire && wLane && (wAddr == OFF_SCREEN_DATA_IN) && !clearing;
   assign wrMode = wrFire && wLane && (wAddr == OFF_SCREEN_MEM_MODE) && !clearing; // [R23]
   // In auto-increment the terminator byte is swallowed
   assign storeData = wrScreenIn && !(screenMemMode[BIT_MODE_AUTO_INC] && wByte == AUTO_INC_END); // [R20]

   // Write address and data channels, taken in either order
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         awHave <= 1'b0;
         wHave <= 1'b0;
         wAddr <= 8'h00;
         wByte <= 8'h00;
         wLane <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !awHave && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !wHave && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHave <= 1'b1;
            wAddr <= s_axi_awaddr;
         end else if (wrFire) begin
            awHave <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHave <= 1'b1;
            wByte <= s_axi_wdata[7:0];
            wLane <= s_axi_wstrb[0];
         end else if (wrFire) begin
            wHave <= 1'b0;
         end
      end
   end

   // Write response, one cycle after both halves are held
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wrFire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Plain control registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         videoModeCtrl0 <= RST_VIDEO_MODE_CTRL_0;
         overlayBlackLevel <= {RST_BLACK_LEVEL_HI, FACTORY_PRESET};
         glyphAddrHigh <= 8'h00;
         glyphAddrLow <= 6'h00;
      end else if (wrFire && wLane) begin
         case (wAddr)
            OFF_VIDEO_MODE_CTRL_0: videoModeCtrl0 <= wByte;
            OFF_OVERLAY_BLACK_LEVEL: overlayBlackLevel <= wByte; // [R8]
            OFF_GLYPH_ADDR_HIGH: glyphAddrHigh <= wByte; // [R2]
            OFF_GLYPH_ADDR_LOW: glyphAddrLow <= wByte[5:0]; // [R3]
            default: ;
         endcase
      end
   end

   // Overlay and black-level outputs; screen access never looks at them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         overlayVisible <= 1'b0;
         blackLevelAuto <= 1'b0;
      end else begin
         overlayVisible <= videoModeCtrl0[BIT_OVERLAY_EN]; // [R7]
         blackLevelAuto <= !overlayBlackLevel[BIT_BLACK_AUTO_N];
      end
   end

   // Glyph memory sequencer: load copies 64 bytes, store copies then holds busy
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         glyphState <= GS_IDLE;
         glyphIdx <= 6'h00;
         storeCnt <= '0;
      end else begin
         case (glyphState)
            GS_IDLE: begin
               glyphIdx <= 6'h00;
               if (wrGlyphCmd && wByte[7:4] == CMD_LOAD_SHADOW) begin
                  glyphState <= GS_LOAD; // [R1]
               end else if (wrGlyphCmd && wByte[7:4] == CMD_STORE_SHADOW) begin
                  glyphState <= GS_STORE;
               end
            end
            GS_LOAD: begin
               glyphIdx <= glyphIdx + 6'h01;
               if (glyphIdx == 6'h3f) begin
                  glyphState <= GS_IDLE;
               end
            end
            GS_STORE: begin
               glyphIdx <= glyphIdx + 6'h01;
               storeCnt <= '0;
               if (glyphIdx == 6'h3f) begin
                  glyphState <= GS_WAIT;
               end
            end
            GS_WAIT: begin
               storeCnt <= storeCnt + 1'b1;
               if (storeCnt >= ST_W'(STORE_CYC - GLYPH_BYTES - 1)) begin
                  glyphState <= GS_IDLE; // [R5]
               end
            end
            default: glyphState <= GS_IDLE;
         endcase
      end
   end

   // Shadow RAM: host byte writes and loads from nonvolatile memory
   always_ff @(posedge clk) begin
      if (glyphState == GS_LOAD) begin
         shadowRam[glyphIdx] <= glyphNvm[nvmBase | 14'(glyphIdx)]; // [R1]
      end else if (wrGlyphIn) begin
         shadowRam[glyphAddrLow] <= wByte; // [R3]
      end
   end

   // Nonvolatile glyph array written from the shadow RAM
   always_ff @(posedge clk) begin
      if (glyphState == GS_STORE) begin
         glyphNvm[nvmBase | 14'(glyphIdx)] <= shadowRam[glyphIdx];
      end
   end

   // Screen mode register with self-clearing clear bit and auto-increment exit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         screenMemMode <= RST_SCREEN_MEM_MODE;
         clearCnt <= '0;
      end else if (clearing) begin
         clearCnt <= clearCnt + 1'b1;
         if (clearCnt >= CLR_W'(CLEAR_CYCLES - 1)) begin
            screenMemMode[BIT_MODE_CLEAR] <= 1'b0; // [R11]
         end
      end else if (wrMode) begin
         screenMemMode <= wByte[6:0]; // [R9] [R12] [R17] [R18]
         clearCnt <= '0;
      end else if (wrScreenIn && screenMemMode[BIT_MODE_AUTO_INC] && wByte == AUTO_INC_END) begin
         screenMemMode[BIT_MODE_AUTO_INC] <= 1'b0; // [R20]
      end
   end

   // Screen address registers, advanced after each stored auto-increment write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         screenAddrHigh <= 2'b00;
         screenAddrLow <= 8'h00;
      end else if (wrFire && wLane && wAddr == OFF_SCREEN_ADDR_HIGH) begin
         screenAddrHigh <= wByte[1:0]; // [R13]
      end else if (wrFire && wLane && wAddr == OFF_SCREEN_ADDR_LOW) begin
         screenAddrLow <= wByte;
      end else if (storeData && screenMemMode[BIT_MODE_AUTO_INC]) begin
         {screenAddrHigh[BIT_POS_MSB], screenAddrLow} <= position + 9'h001; // [R19]
      end
   end

   // Per-position valid flags: a clear empties the whole screen at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         screenValid <= '0;
      end else if (wrMode && wByte[BIT_MODE_CLEAR]) begin
         screenValid <= '0; // [R9]
      end else if (storeData) begin
         screenValid[position] <= 1'b1;
      end
   end

   // Screen code and attribute planes
   always_ff @(posedge clk) begin
      if (storeData) begin
         if (!screenMemMode[BIT_MODE_BYTE_WIDE]) begin
            screenCode[position] <= wByte; // [R15]
            screenAttr[position] <= screenMemMode[BIT_ATTR_LO+2:BIT_ATTR_LO]; // [R16]
         end else if (screenAddrHigh[BIT_SEL_ATTR]) begin
            screenAttr[position] <= wByte[7:5]; // [R12] [R13]
            if (!screenValid[position]) begin
               screenCode[position] <= 8'h00;
            end
         end else begin
            screenCode[position] <= wByte; // [R13] [R15]
            if (!screenValid[position]) begin
               screenAttr[position] <= 3'b000;
            end
         end
      end
   end

   // Read data selection
   always_comb begin
      next_rdata = 8'h00;
      next_rerr = 1'b0;
      case (s_axi_araddr)
         OFF_VIDEO_MODE_CTRL_0: next_rdata = videoModeCtrl0;
         OFF_OVERLAY_BLACK_LEVEL: next_rdata = overlayBlackLevel;
         OFF_GLYPH_ADDR_HIGH: next_rdata = glyphAddrHigh;
         OFF_GLYPH_ADDR_LOW: next_rdata = {2'b00, glyphAddrLow};
         OFF_GLYPH_DATA_IN, OFF_GLYPH_MEM_MODE: next_rdata = 8'h00;
         OFF_GLYPH_DATA_OUT: next_rdata = shadowRam[glyphAddrLow]; // [R4] [R22]
         OFF_SCREEN_MEM_MODE: next_rdata = {1'b0, screenMemMode};
         OFF_SCREEN_ADDR_HIGH: next_rdata = {6'h00, screenAddrHigh};
         OFF_SCREEN_ADDR_LOW: next_rdata = screenAddrLow;
         OFF_SCREEN_DATA_IN, OFF_SCREEN_DATA_OUT: next_rdata = 8'h00;
         OFF_STATUS: next_rdata = 8'(glyphBusy) << BIT_STATUS_GLYPH_BUSY; // [R5] [R21]
         default: next_rerr = 1'b1;
      endcase
   end

   // Read channel: address taken, data one cycle later
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= next_rerr ? RESP_SLVERR : RESP_OKAY;
            if (s_axi_araddr == OFF_SCREEN_DATA_OUT) begin
               if (!screenValid[position]) begin
                  s_axi_rdata <= 32'h0000_0000;
               end else if (screenMemMode[BIT_MODE_BYTE_WIDE] && screenAddrHigh[BIT_SEL_ATTR]) begin
                  s_axi_rdata <= {24'h000000, screenAttr[position], 5'h00};
               end else if (screenMemMode[BIT_MODE_BYTE_WIDE]) begin
                  s_axi_rdata <= {24'h000000, screenCode[position]};
               end else begin
                  s_axi_rdata <= {16'h0000, 1'b0, screenAttr[position], 4'h0, screenCode[position]};
               end
            end else begin
               s_axi_rdata <= {24'h000000, next_rdata};
            end
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// >>> verilog/osdm_pkg.sv
// Package with register map, field positions, reset values and timing for the OSD memory access block
package osdm_pkg;
   // Register byte offsets on the AXI4-Lite bus
   localparam logic [7:0] OFF_VIDEO_MODE_CTRL_0 = 8'h00;
   localparam logic [7:0] OFF_OVERLAY_BLACK_LEVEL = 8'h04;
   localparam logic [7:0] OFF_GLYPH_ADDR_HIGH = 8'h08;
   localparam logic [7:0] OFF_GLYPH_ADDR_LOW = 8'h0c;
   localparam logic [7:0] OFF_GLYPH_DATA_IN = 8'h10;
   localparam logic [7:0] OFF_GLYPH_DATA_OUT = 8'h14;
   localparam logic [7:0] OFF_GLYPH_MEM_MODE = 8'h18;
   localparam logic [7:0] OFF_SCREEN_MEM_MODE = 8'h1c;
   localparam logic [7:0] OFF_SCREEN_ADDR_HIGH = 8'h20;
   localparam logic [7:0] OFF_SCREEN_ADDR_LOW = 8'h24;
   localparam logic [7:0] OFF_SCREEN_DATA_IN = 8'h28;
   localparam logic [7:0] OFF_SCREEN_DATA_OUT = 8'h2c;
   localparam logic [7:0] OFF_STATUS = 8'h30;
   // Field positions
   localparam int BIT_OVERLAY_EN = 3;
   localparam int BIT_BLACK_AUTO_N = 4;
   localparam int BIT_STATUS_GLYPH_BUSY = 5;
   localparam int BIT_MODE_AUTO_INC = 0;
   localparam int BIT_MODE_CLEAR = 2;
   localparam int BIT_MODE_BYTE_WIDE = 6;
   localparam int BIT_ATTR_LO = 3;
   localparam int BIT_SEL_ATTR = 1;
   localparam int BIT_POS_MSB = 0;
   // Glyph memory commands on the upper nibble
   localparam logic [3:0] CMD_LOAD_SHADOW = 4'h5;
   localparam logic [3:0] CMD_STORE_SHADOW = 4'ha;
   // Auto-increment terminator
   localparam logic [7:0] AUTO_INC_END = 8'hff;
   // Reset values
   localparam logic [7:0] RST_VIDEO_MODE_CTRL_0 = 8'h00;
   localparam logic [3:0] RST_BLACK_LEVEL_HI = 4'h1;
   localparam logic [6:0] RST_SCREEN_MEM_MODE = 7'h00;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Timing
   localparam int CLK_HZ = 10_000_000;
   localparam int STORE_TIME_MS = 12;
   localparam int CLEAR_TIME_US = 20;
   localparam int STORE_CYCLES = STORE_TIME_MS * (CLK_HZ / 1000);
   localparam int CLEAR_CYCLES = CLEAR_TIME_US * (CLK_HZ / 1_000_000);
   // Sizes
   localparam int GLYPH_COUNT = 256;
   localparam int GLYPH_BYTES = 64;
   localparam int SCREEN_POSITIONS = 512;
   // Glyph memory sequencer states
   typedef enum logic [1:0] {GS_IDLE, GS_LOAD, GS_STORE, GS_WAIT} osdm_glyph_state_t;
endpackage

// >>> dv/osdm_access_ctrl_asserts.sv
// Bus handshake and register-effect checks for the OSD memory access block
`timescale 1ns/10ps
`default_nettype none
module osdm_access_ctrl_asserts
   import osdm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic overlayVisible,
   input wire logic blackLevelAuto
);
   logic [7:0] awA;
   logic [7:0] arA;
   logic [31:0] wD;
   logic wS;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Offsets that answer OKAY
   function automatic logic rdOk(input logic [7:0] a);
      return a[1:0] == 2'b00 && a <= OFF_STATUS;
   endfunction
   function automatic logic wrOk(input logic [7:0] a);
      return rdOk(a) && a != OFF_GLYPH_DATA_OUT && a != OFF_SCREEN_DATA_OUT && a != OFF_STATUS;
   endfunction
   // Keeps address and data of the transfer in flight
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         awA <= 8'h00;
         arA <= 8'h00;
         wD <= 32'h0;
         wS <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) awA <= s_axi_awaddr;
         if (s_axi_arvalid && s_axi_arready) arA <= s_axi_araddr;
         if (s_axi_wvalid && s_axi_wready) wD <= s_axi_wdata;
         if (s_axi_wvalid && s_axi_wready) wS <= s_axi_wstrb[0];
      end
   end
   chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready held");
   chk_w_pulse: assert property (s_axi_wready |=> !s_axi_wready)
      else $error("wready held");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   chk_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   chk_wr_resp: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp == (wrOk(awA) ? RESP_OKAY : RESP_SLVERR))
      else $error("write response wrong");
   chk_rd_resp: assert property ($rose(s_axi_rvalid) |-> s_axi_rresp == (rdOk(arA) ? RESP_OKAY : RESP_SLVERR))
      else $error("read response wrong");
   chk_overlay_follow: assert property ($rose(s_axi_bvalid) && awA == OFF_VIDEO_MODE_CTRL_0 && wS
      |=> overlayVisible == wD[BIT_OVERLAY_EN]) else $error("overlay output wrong");
   chk_black_follow: assert property ($rose(s_axi_bvalid) && awA == OFF_OVERLAY_BLACK_LEVEL && wS
      |=> blackLevelAuto == !wD[BIT_BLACK_AUTO_N]) else $error("black level output wrong");
   cover property ($rose(s_axi_bvalid) && s_axi_bresp == RESP_SLVERR);
   cover property ($rose(overlayVisible));
   cover property ($rose(blackLevelAuto));
endmodule
bind osdm_access_ctrl osdm_access_ctrl_asserts chk (.*);
`default_nettype wire

// >>> dv/osdm_host.sv
// Register-bus host model: one write or one read at a time, answers taken at the rising edge
`timescale 1ns/10ps
`default_nettype none
module osdm_host (
   input wire logic clk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // Idle bus at time zero
   initial begin
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b1;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b1;
   end
   // Write; released payload is inverted so stale values never match
   // Ready for the answer stays high, so the answer is taken at the edge it is seen
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r, output bit ok);
      bit at;
      bit wt;
      int n;
      ok = 0;
      r = 2'b11;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 40 && !ok; n++) begin
         @(posedge clk);
         at = s_axi_awvalid && s_axi_awready;
         wt = s_axi_wvalid && s_axi_wready;
         ok = s_axi_bvalid && s_axi_bready;
         r = s_axi_bresp;
         if (at) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (wt) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
      end
   endtask
   // Read; data and response taken at the edge where rvalid is seen
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r, output bit ok);
      bit t;
      int n;
      ok = 0;
      d = 32'hffff_ffff;
      r = 2'b11;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 40 && !ok; n++) begin
         @(posedge clk);
         t = s_axi_arvalid && s_axi_arready;
         ok = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         if (t) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
      end
   endtask
endmodule
`default_nettype wire

// >>> dv/osd_memory_access_control_tb_top.sv
// Self-checking bench: host model drives the block, expectations from a bench model
`timescale 1ns/10ps
`default_nettype none
module osd_memory_access_control_tb_top;
   import osdm_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, overlayVisible, blackLevelAuto;
   int numErrors = 0;
   int compares = 0;
   int i, p, c;
   logic [7:0] lf = 8'h4c;
   logic [7:0] nvm[int];
   logic [7:0] scr[int];
   always #50 clk = ~clk;
   // Preset value is arbitrary; nonzero so a lost preset bit shows
   osdm_access_ctrl #(.STORE_CYC(100), .FACTORY_PRESET(4'h9)) uut (.*);
   osdm_host h (.*);
   function automatic logic [7:0] nxt(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   task automatic report_and_stop;
      $display("compares %0d errors %0d", compares, numErrors);
      if (numErrors == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chkData(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         numErrors++;
         $display("CHECK FAILED at %0t data %h expected %h", $time, g, e);
      end
   endtask
   task automatic chkResp(input logic [1:0] g, input logic [1:0] e);
      compares++;
      if (g !== e) begin
         numErrors++;
         $display("CHECK FAILED at %0t resp %h expected %h", $time, g, e);
      end
   endtask
   task automatic w(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
      logic [1:0] r;
      bit ok;
      h.wr(a, {24'h0, d}, r, ok);
      if (!ok) begin
         numErrors++;
         report_and_stop;
      end
      chkResp(r, er);
   endtask
   task automatic rx(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
      logic [31:0] d;
      logic [1:0] r;
      bit ok;
      h.rd(a, d, r, ok);
      if (!ok) begin
         numErrors++;
         report_and_stop;
      end
      chkResp(r, er);
      if (er == RESP_OKAY) chkData(d, e);
   endtask
   // Polls a register until one bit reads zero, bounded
   task automatic waitLow(input logic [7:0] a, input int b);
      logic [31:0] d;
      logic [1:0] r;
      bit ok;
      int n;
      d = 32'hffff_ffff;
      for (n = 0; n < 80 && d[b] !== 1'b0; n++) h.rd(a, d, r, ok);
      if (d[b] !== 1'b0) begin
         numErrors++;
         report_and_stop;
      end
   endtask
   task automatic seek(input int q, input logic sel);
      w(8'h20, {6'h0, sel, q[8]});
      w(8'h24, q[7:0]);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // Reset values, unmapped and read-only places
      rx(8'h00, 32'h0);
      rx(8'h04, 32'h19);
      rx(8'h30, 32'h0);
      w(8'h34, 8'h01, RESP_SLVERR);
      w(8'h2c, 8'h01, RESP_SLVERR);
      rx(8'h42, 32'h0, RESP_SLVERR);
      // Only bit 4 changes, preset bits written back
      w(8'h04, 8'h19 & 8'hef);
      rx(8'h04, 32'h09);
      chkData({31'h0, blackLevelAuto}, 32'h1);
      // Glyphs 3 and 255: fill two shadow bytes, read back, store
      w(8'h00, 8'h00);
      for (c = 3; c < 256; c += 252) begin
         w(8'h08, c[7:0]);
         for (i = 0; i < 64; i += 63) begin
            lf = nxt(lf);
            nvm[c * 64 + i] = lf;
            w(8'h0c, i[7:0]);
            w(8'h10, lf);
            rx(8'h14, {24'h0, lf});
         end
         w(8'h18, 8'ha7);
         rx(8'h30, 32'h20);
         w(8'h10, ~lf);
         waitLow(8'h30, 5);
         rx(8'h14, {24'h0, lf});
      end
      // Reload glyph 3 over a shadow holding glyph 255
      w(8'h08, 8'h03);
      w(8'h18, 8'h5b);
      rx(8'h30, 32'h20);
      waitLow(8'h30, 5);
      for (i = 0; i < 64; i += 63) begin
         w(8'h0c, i[7:0]);
         rx(8'h14, {24'h0, nvm[192 + i]});
      end
      w(8'h00, 8'h08);
      rx(8'h00, 32'h08);
      chkData({31'h0, overlayVisible}, 32'h1);
      // Word mode copies flags 101 with each code
      w(8'h1c, 8'h28);
      for (p = 0; p < 512; p += 255) begin
         lf = nxt(lf);
         scr[p] = lf;
         seek(p, 1'b0);
         w(8'h28, lf);
         rx(8'h2c, {16'h0, 8'h50, lf});
      end
      // Byte mode writes the planes apart
      w(8'h1c, 8'h40);
      seek(255, 1'b1);
      w(8'h28, 8'hc0);
      rx(8'h2c, 32'hc0);
      seek(510, 1'b0);
      rx(8'h2c, {24'h0, scr[510]});
      // Auto-increment across the wrap, ended by the terminator
      w(8'h1c, 8'h01);
      seek(510, 1'b0);
      for (i = 510; i < 513; i++) begin
         lf = nxt(lf);
         scr[i % 512] = lf & 8'h7f;
         w(8'h28, scr[i % 512]);
      end
      w(8'h28, 8'hff);
      rx(8'h1c, 32'h0);
      scr[1] = 8'h00;
      for (i = 510; i < 514; i++) begin
         seek(i % 512, 1'b0);
         rx(8'h2c, {24'h0, scr[i % 512]});
      end
      seek(255, 1'b0);
      rx(8'h2c, {16'h0, 8'h60, scr[255]});
      // Clear refuses mode writes until its bit drops
      w(8'h1c, 8'h04);
      rx(8'h1c, 32'h04);
      w(8'h1c, 8'h41);
      w(8'h28, 8'h33);
      rx(8'h2c, 32'h0);
      waitLow(8'h1c, 2);
      rx(8'h1c, 32'h0);
      report_and_stop;
   end
endmodule
`default_nettype wire
